//--- rtl/fcpp_pkg.sv
// Package of the flash page-program command sequencer.
// Assumes a single 200 MHz clock domain shared by CPU stores, APB and array.
package fcpp_pkg;

  // Command data keys of the store sequence
  localparam logic [31:0] FCPP_KEY1      = 32'h0000_00AA;
  localparam logic [31:0] FCPP_KEY2      = 32'h0000_0055;
  localparam logic [31:0] FCPP_KEY_PROG  = 32'h0000_00A0;
  localparam logic [31:0] FCPP_KEY_READ  = 32'h0000_00F0;

  // Command address field and its expected values per cycle
  localparam int          FCPP_CADDR_HI  = 18;
  localparam int          FCPP_CADDR_LO  = 8;
  localparam logic [10:0] FCPP_CADDR_1   = 11'h055;
  localparam logic [10:0] FCPP_CADDR_2   = 11'h02A;

  // Chip select field and read-command range bit
  localparam int          FCPP_CHIP_HI   = 20;
  localparam int          FCPP_CHIP_LO   = 19;
  localparam int          FCPP_RANGE_BIT = 20;

  // Page geometry: words share the upper address bits
  localparam int          FCPP_PAGE_LO   = 9;
  localparam int          FCPP_WORDS     = 128;
  localparam logic [8:0]  FCPP_PAGE_TOP  = 9'h000;
  localparam int          FCPP_WIDX_W    = 7;

  // APB register offsets
  localparam logic [11:0] FCPP_OFF_STAT  = 12'h000;
  localparam logic [11:0] FCPP_OFF_CTRL  = 12'h004;
  localparam logic [11:0] FCPP_OFF_WCNT  = 12'h008;

  // Status and control fields
  localparam int          FCPP_ST_DONE   = 0;
  localparam int          FCPP_ST_READ   = 1;
  localparam int          FCPP_ST_LOCK   = 2;
  localparam int          FCPP_ST_FAIL   = 3;
  localparam int          FCPP_CT_EN     = 0;
  localparam logic        FCPP_CT_RESET  = 1'b1;

  // Word store from the CPU core
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } fcpp_store_t;

  // Program request to the flash array
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [31:0] data;
  } fcpp_prog_t;

  typedef enum logic [3:0] {
    FCPP_READ, FCPP_C1, FCPP_C2, FCPP_RD1, FCPP_PG_TOP,
    FCPP_PG_DATA, FCPP_PG_WAIT, FCPP_LOCKED
  } fcpp_state_t;

endpackage : fcpp_pkg

//--- rtl/fcpp_seq.sv
// Flash page-program command sequencer with APB status and control.
// Assumes CPU word stores arrive as one-cycle pulses on pclk and that the
// flash array answers each program word with prog_ack (and prog_fail).
// Function
// R1: Read mode and automatic mode; enter by sequence
// R2: Read mode after reset and normal finish
// R3: Abnormal end stays out of read mode
// R4: F0 to two ranges returns read mode
// R5: Read/reset returns after third write
// R6: Wrong address or data abandons to read
// R7: Host keeps chip select bits fixed
// R8: Host spaces writes by fifteen clocks
// R9: Host avoids flash reads between writes
// R10: Host follows stores with barrier
// R11: Host checks done flag before commanding
// R12: Hardware reset aborts, returns read mode
// R13: Programming only clears bits to zero
// R14: Page is 128 words, same upper bits
// R15: Fourth write starts, then successive words
// R16: New commands ignored while page programs
// R17: Host programs each erased page once
// R18: Partial update pads with all ones
// R19: Normal finish sets done, read mode
// R20: Data crossing page is not processed
// R21: Protected or failed program locks out
// R22: Software reset ignored from fourth write
// R23: Count writes, match table, busy flag
//
// Chosen here: the placing of the registers and the APB register port.
module fcpp_seq
  import fcpp_pkg::*;
#(
  parameter int WORDS = FCPP_WORDS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU word stores into the flash space
  input  fcpp_store_t      store,
  // Flash array program port
  output fcpp_prog_t       prog,
  input  wire logic        prog_ack,
  input  wire logic        prog_fail,
  input  wire logic        page_protected,
  // Array read gating and flag
  output logic             array_read_ok,
  output logic             op_done_flag
);

  fcpp_state_t             state, next_state;
  logic                    from_lock, next_from_lock;
  logic [1:0]              chip, next_chip;
  logic [31:FCPP_PAGE_LO]  page, next_page;
  logic [FCPP_WIDX_W:0]    widx, next_widx;
  fcpp_prog_t              next_prog;
  logic                    fail, next_fail;
  logic                    seq_en, next_seq_en;
  logic [31:0]             next_prdata;

  logic                    st;
  logic [10:0]             caddr;
  logic                    chip_ok;
  logic                    is_key1, is_key2, is_prog, is_read;
  logic                    apb_wr, apb_rd;
  logic                    ctl_reset;

  // Decode of the incoming store against the command table
  assign st      = store.valid && seq_en;
  assign caddr   = store.addr[FCPP_CADDR_HI:FCPP_CADDR_LO];
  assign chip_ok = (store.addr[FCPP_CHIP_HI:FCPP_CHIP_LO] == chip); // R7
  assign is_key1 = (store.data == FCPP_KEY1) && (caddr == FCPP_CADDR_1);
  assign is_key2 = (store.data == FCPP_KEY2) && (caddr == FCPP_CADDR_2) && chip_ok;
  assign is_prog = (store.data == FCPP_KEY_PROG) && (caddr == FCPP_CADDR_1) && chip_ok;
  assign is_read = (store.data == FCPP_KEY_READ);

  // APB strobes; slave answers in the access cycle with no wait states
  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = psel && !penable && !pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && (paddr != FCPP_OFF_STAT)
                     && (paddr != FCPP_OFF_CTRL) && (paddr != FCPP_OFF_WCNT);
  assign ctl_reset = apb_wr && (paddr == FCPP_OFF_CTRL) && pwdata[1];

  // Flag and read gating follow the state directly
  always_comb begin
    array_read_ok = (state == FCPP_READ) || (state == FCPP_C1)
                    || (state == FCPP_C2) || (state == FCPP_RD1);     // R1
    if (from_lock) begin
      array_read_ok = 1'b0;                                           // R3
    end
    op_done_flag  = array_read_ok;                                    // R23
  end

  // Command sequencer next state
  always_comb begin
    next_state     = state;
    next_from_lock = from_lock;
    next_chip      = chip;
    next_page      = page;
    next_widx      = widx;
    next_fail      = fail;
    next_prog      = prog;
    if (prog_ack) begin
      next_prog.req = 1'b0;
    end
    case (state)
      FCPP_READ, FCPP_LOCKED: begin
        next_from_lock = (state == FCPP_LOCKED);
        if (st && is_key1) begin
          next_chip  = store.addr[FCPP_CHIP_HI:FCPP_CHIP_LO];
          next_state = FCPP_C1;                                       // R23
        end else if (st && is_read && store.addr[FCPP_RANGE_BIT]) begin
          next_state = FCPP_RD1;                                      // R4
        end
      end
      FCPP_RD1: begin
        if (st) begin
          if (is_read && !store.addr[FCPP_RANGE_BIT]) begin
            next_state     = FCPP_READ;                               // R4
            next_from_lock = 1'b0;
          end else begin
            next_state = from_lock ? FCPP_LOCKED : FCPP_READ;         // R6
          end
        end
      end
      FCPP_C1: begin
        if (st) begin
          next_state = is_key2 ? FCPP_C2 : (from_lock ? FCPP_LOCKED : FCPP_READ); // R6
        end
      end
      FCPP_C2: begin
        if (st) begin
          if (is_read && chip_ok) begin
            next_state     = FCPP_READ;                               // R5
            next_from_lock = 1'b0;
          end else if (is_prog && !from_lock) begin
            next_state = FCPP_PG_TOP;                                 // R1
          end else begin
            next_state = from_lock ? FCPP_LOCKED : FCPP_READ;         // R6
          end
        end
      end
      FCPP_PG_TOP: begin
        // Fourth write: page top address with its data; no reset key here
        if (st) begin
          if (store.addr[FCPP_PAGE_LO-1:0] != FCPP_PAGE_TOP) begin
            next_state = FCPP_READ;                                   // R6
          end else if (page_protected) begin
            next_state = FCPP_LOCKED;                                 // R21
            next_fail  = 1'b1;
          end else begin
            next_page      = store.addr[31:FCPP_PAGE_LO];             // R14
            next_prog.req  = 1'b1;                                    // R15
            next_prog.addr = store.addr;
            next_prog.data = store.data;                              // R13
            next_widx      = '0;
            next_state     = FCPP_PG_WAIT;
          end
        end
      end
      FCPP_PG_DATA: begin
        // Every store inside the page is data; commands including read/reset are ignored
        if (st && (store.addr[31:FCPP_PAGE_LO] == page)) begin        // R20
          next_prog.req  = 1'b1;
          next_prog.addr = {page, widx[FCPP_WIDX_W-1:0], 2'b00};      // R15
          next_prog.data = store.data;                                // R13
          next_state     = FCPP_PG_WAIT;                              // R16 R22
        end
      end
      FCPP_PG_WAIT: begin
        if (prog_ack) begin
          if (prog_fail) begin
            next_state = FCPP_LOCKED;                                 // R21
            next_fail  = 1'b1;
          end else if (widx == (FCPP_WIDX_W+1)'(WORDS - 1)) begin
            next_state     = FCPP_READ;                               // R19
            next_from_lock = 1'b0;
          end else begin
            next_widx  = widx + 1'b1;
            next_state = FCPP_PG_DATA;
          end
        end
      end
      default: begin
        next_state = FCPP_READ;
      end
    endcase
    // Software clear of the failure report; a new failure (entry to lock) wins
    if (ctl_reset && !((next_state == FCPP_LOCKED) && (state != FCPP_LOCKED))) begin
      next_fail = 1'b0;
    end
  end

  // Sequencer registers; hardware reset aborts everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= FCPP_READ;                                         // R2 R12
      from_lock <= 1'b0;
      chip      <= 2'h0;
      page      <= '0;
      widx      <= '0;
      fail      <= 1'b0;
      prog      <= '0;
    end else begin
      state     <= next_state;
      from_lock <= next_from_lock;
      chip      <= next_chip;
      page      <= next_page;
      widx      <= next_widx;
      fail      <= next_fail;
      prog      <= next_prog;
    end
  end

  // APB register next values; read data captured at setup
  always_comb begin
    next_seq_en = seq_en;
    next_prdata = prdata;
    if (apb_wr && (paddr == FCPP_OFF_CTRL)) begin
      next_seq_en = pwdata[FCPP_CT_EN];
    end
    if (apb_rd) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        FCPP_OFF_STAT: begin
          next_prdata[FCPP_ST_DONE] = op_done_flag;
          next_prdata[FCPP_ST_READ] = array_read_ok;
          next_prdata[FCPP_ST_LOCK] = (state == FCPP_LOCKED);
          next_prdata[FCPP_ST_FAIL] = fail;
        end
        FCPP_OFF_CTRL: begin
          next_prdata[FCPP_CT_EN] = seq_en;
        end
        FCPP_OFF_WCNT: begin
          next_prdata[FCPP_WIDX_W:0] = widx;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_en <= FCPP_CT_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      seq_en <= next_seq_en;
      prdata <= next_prdata;
    end
  end

endmodule : fcpp_seq

//--- dv/fcpp_seq_chk.sv
// Port checker for the page-program sequencer.
// Assumes one pclk domain reset by presetn.
module fcpp_seq_chk
  import fcpp_pkg::*;
(
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Watched ports
  input fcpp_store_t store,
  input fcpp_prog_t  prog,
  input wire logic   prog_ack,
  input wire logic   prog_fail,
  input wire logic   array_read_ok,
  input wire logic   op_done_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // First word of a page: ready seen since the last array answer
  logic first_word;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_word <= 1'b1;
    end else if (op_done_flag) begin
      first_word <= 1'b1;
    end else if (prog_ack) begin
      first_word <= 1'b0;
    end
  end

  property p_mode; op_done_flag == array_read_ok; endproperty
  a_mode: assert property (p_mode) else $error("flag and read gate differ");
  property p_reset; $rose(presetn) |-> op_done_flag; endproperty
  a_reset: assert property (p_reset) else $error("not ready after reset");
  property p_drop; prog.req && prog_ack |=> !prog.req; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_data;
    $rose(prog.req) |-> $past(store.valid) && prog.data == $past(store.data);
  endproperty
  a_data: assert property (p_data) else $error("word not from last store");
  property p_top;
    $rose(prog.req) && first_word |-> prog.addr[8:0] == FCPP_PAGE_TOP;
  endproperty
  a_top: assert property (p_top) else $error("first word not at page top");
  property p_fail; prog_ack && prog_fail |=> !op_done_flag [*2]; endproperty
  a_fail: assert property (p_fail) else $error("failed word not locked");
  property p_done;
    prog_ack && !prog_fail && prog.req && prog.addr[8:0] == 9'h1FC |=> op_done_flag;
  endproperty
  a_done: assert property (p_done) else $error("page end not ready");
  property p_ignore; prog.req && !prog_ack |=> !op_done_flag; endproperty
  a_ignore: assert property (p_ignore) else $error("ready while programming");
endmodule : fcpp_seq_chk

bind fcpp_seq fcpp_seq_chk u_chk (
  .pclk(pclk), .presetn(presetn), .store(store), .prog(prog), .prog_ack(prog_ack),
  .prog_fail(prog_fail), .array_read_ok(array_read_ok), .op_done_flag(op_done_flag));

//--- dv/fcpp_array_model.sv
// Flash array model answering program words.
// Assumes req holds until acked; latency stays under the store spacing.
module fcpp_array_model
  import fcpp_pkg::*;
(
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Program port
  input fcpp_prog_t   prog,
  output logic        prog_ack,
  output logic        prog_fail,
  // Bench controls and tallies
  input wire logic    slow,
  input wire logic    fail_all,
  output logic [31:0] nacks,
  output logic [31:0] last_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  initial nacks = 32'h0;
  // Fail means nothing without ack, so it wanders there
  assign prog_fail = prog_ack ? fail_all : cnt[0];
  // Ack after a prompt or slow wait; tallies survive reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      prog_ack <= 1'b0;
    end else begin
      prog_ack <= 1'b0;
      if (prog.req && !prog_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt >= (slow ? 4'h9 : 4'h0)) begin
          prog_ack <= 1'b1;
          cnt <= 4'h0;
          nacks <= nacks + 32'h1;
          last_addr <= prog.addr;
        end
      end
    end
  end
endmodule : fcpp_array_model

//--- dv/fcpp_seq_test.sv
// Bench for the page-program sequencer: CPU stores, APB and array model.
// Assumes the default 128-word page.
module fcpp_seq_test;
  import fcpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        prog_ack, prog_fail, page_protected, array_read_ok, op_done_flag;
  logic        slow, fail_all;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, n0, nacks, last_addr;
  fcpp_store_t store;
  fcpp_prog_t  prog;
  int          num_errors, total_checks, cyc;

  fcpp_seq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .store(store), .prog(prog), .prog_ack(prog_ack),
    .prog_fail(prog_fail), .page_protected(page_protected),
    .array_read_ok(array_read_ok), .op_done_flag(op_done_flag));
  fcpp_array_model u_array (.pclk(pclk), .presetn(presetn), .prog(prog),
    .prog_ack(prog_ack), .prog_fail(prog_fail), .slow(slow), .fail_all(fail_all),
    .nacks(nacks), .last_addr(last_addr));

  // 200 MHz clock and a hang limit
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One word store; released lines show inverted values
  task automatic st(input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    store <= '{1'b1, a, d};
    @(posedge pclk);
    store <= '{1'b0, ~a, ~d};
    repeat (15) @(posedge pclk);
  endtask : st

  task automatic cmd(input logic [31:0] d3);
    st(32'h0000_5500, FCPP_KEY1);
    st(32'h0000_2A00, FCPP_KEY2);
    st(32'h0000_5500, d3);
  endtask : cmd

  // Page program of n words; top word all ones, later words mimic the read key
  task automatic page(input logic [31:0] base, input int n);
    chk("ready before command", op_done_flag, 1);
    cmd(FCPP_KEY_PROG);
    for (int i = 0; i < n; i++) begin
      st(base | {23'h0, i[6:0], 2'b00}, (i == 0) ? 32'hFFFF_FFFF : FCPP_KEY_READ);
      if (i == 0) chk("busy after top", op_done_flag, 0);
    end
  endtask : page

  task automatic hw_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : hw_reset

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    {pclk, psel, penable, pwrite, page_protected, slow, fail_all, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    store = '0;
    cyc = 0;
    hw_reset();
    chk("flag after reset", op_done_flag, 1);
    apb(1'b0, FCPP_OFF_STAT, 32'h0);
    chk("status after reset", q, 32'h3);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped error", err, 1);
    chk("unmapped data", q, 0);
    cmd(FCPP_KEY1);
    st(32'h0000_4000, FCPP_KEY_READ);
    chk("broken sequence", op_done_flag, 1);
    slow <= 1'b1;
    n0 = nacks;
    page(32'h0000_4000, 128);
    chk("flag after page", op_done_flag, 1);
    chk("words programmed", nacks - n0, 128);
    chk("last word", last_addr, 32'h0000_41FC);
    apb(1'b0, FCPP_OFF_WCNT, 32'h0);
    chk("word index", q, 32'h7F);
    slow <= 1'b0;
    fail_all <= 1'b1;
    page(32'h0000_4200, 1);
    chk("locked on fail", op_done_flag, 0);
    fail_all <= 1'b0;
    cmd(FCPP_KEY_READ);
    chk("read reset", op_done_flag, 1);
    page_protected <= 1'b1;
    page(32'h0000_4400, 1);
    chk("protected", op_done_flag, 0);
    apb(1'b0, FCPP_OFF_STAT, 32'h0);
    chk("locked status", q, 32'hC);
    page_protected <= 1'b0;
    st(32'h0010_0000, FCPP_KEY_READ);
    st(32'h0000_0000, FCPP_KEY_READ);
    chk("read command", op_done_flag, 1);
    apb(1'b0, FCPP_OFF_STAT, 32'h0);
    chk("fail sticky", q, 32'hB);
    apb(1'b1, FCPP_OFF_CTRL, 32'h3);
    apb(1'b0, FCPP_OFF_STAT, 32'h0);
    chk("fail cleared", q, 32'h3);
    apb(1'b1, FCPP_OFF_CTRL, 32'h0);
    n0 = nacks;
    cmd(FCPP_KEY_PROG);
    st(32'h0000_4800, 32'hFFFF_FFFF);
    chk("stores disabled", op_done_flag, 1);
    chk("no word when disabled", nacks - n0, 0);
    apb(1'b0, FCPP_OFF_CTRL, 32'h0);
    chk("control readback", q, 32'h0);
    apb(1'b1, FCPP_OFF_CTRL, 32'h1);
    page(32'h0000_4600, 3);
    hw_reset();
    chk("hw reset", op_done_flag, 1);
    finish_test();
  end
endmodule : fcpp_seq_test
